// ---- hw/shcfg_defines.svh ----
// Offsets, field positions and defaults of the configuration bank.
// Assumes shcfg_pkg is compiled alongside.
`ifndef SHCFG_DEFINES_SVH
`define SHCFG_DEFINES_SVH

// Register indices; byte address is four times the index
`define SHCFG_IDX_OUT_PATH      8'h0a
`define SHCFG_IDX_MODE_SYNC     8'h0b
`define SHCFG_IDX_LOCK_HOLD     8'h0c
`define SHCFG_IDX_HOLD_PIN      8'h0d
`define SHCFG_IDX_SIG_LOSS      8'h0e
// Reset command word and status word
`define SHCFG_IDX_DEV_RESET     8'h00
`define SHCFG_IDX_STATUS        8'h10

// Register defaults
`define SHCFG_RST_OUT_PATH      32'h00000200
`define SHCFG_RST_MODE_SYNC     32'h05811000
`define SHCFG_RST_LOCK_HOLD     32'h1b000180
`define SHCFG_RST_HOLD_PIN      32'h3b020660
`define SHCFG_RST_SIG_LOSS      32'h12000000

// Field positions
`define SHCFG_B_OSC_PATH        12
`define SHCFG_B_FB_MUX_EN       11
`define SHCFG_B_FB_SEL_HI       7
`define SHCFG_B_FB_SEL_LO       5
`define SHCFG_B_EXCL_HI         25
`define SHCFG_B_EXCL_LO         20
`define SHCFG_B_ALIGN_OUT_HI    19
`define SHCFG_B_ALIGN_OUT_LO    18
`define SHCFG_B_ALIGN_QUAL      17
`define SHCFG_B_ALIGN_POL       16
`define SHCFG_B_ALIGN_AUTO      15
`define SHCFG_B_XTAL_EN         5
`define SHCFG_B_LOCK_SEL_HI     31
`define SHCFG_B_LOCK_SEL_LO     27
`define SHCFG_B_ALIGN_L2        23
`define SHCFG_B_ALIGN_L1        22
`define SHCFG_B_TRACK           8
`define SHCFG_B_HOLD_HI         7
`define SHCFG_B_HOLD_LO         6
`define SHCFG_B_L1_TRIG_OFF     15
`define SHCFG_B_SEL_MODE_HI     11
`define SHCFG_B_SEL_MODE_LO     9
`define SHCFG_B_PIN_INV         8
`define SHCFG_B_REF1_OK         6
`define SHCFG_B_REF0_OK         5
`define SHCFG_B_LOSS_TO_HI      31
`define SHCFG_B_LOSS_TO_LO      30
`define SHCFG_B_LOSS_ON         28
`define SHCFG_B_ST1_TYPE_HI     26
`define SHCFG_B_ST1_TYPE_LO     24
`define SHCFG_B_DEV_RESET       17

// Codes
`define SHCFG_SEL_MODE_PIN      3'h6
`define SHCFG_HOLD_AUTO         2'h2

// Loss timeout for code 0, and its cycles at 125 MHz
`define SHCFG_LOSS_TO0_NS       1200
`define SHCFG_CLK_PERIOD_NS     8
`define SHCFG_LOSS_TO0_CYC      ((`SHCFG_LOSS_TO0_NS + `SHCFG_CLK_PERIOD_NS - 1) / `SHCFG_CLK_PERIOD_NS)

`endif

// ---- hw/shcfg_pkg.sv ----
// Types shared by the configuration bank.
// Assumes nothing beyond a SystemVerilog compiler.
package shcfg_pkg;
    typedef enum logic [1:0] {
        SHCFG_RESP_OKAY   = 2'h0,
        SHCFG_RESP_SLVERR = 2'h2
    } shcfg_resp_e;

    // Bus write side status, travels together
    typedef struct packed {
        logic        valid;
        shcfg_resp_e resp;
    } shcfg_bresp_s;

    // Decoded controls handed to the analog and pin logic
    typedef struct packed {
        logic       osc_path_select;
        logic       feedback_mux_power;
        logic [2:0] feedback_select;
        logic [5:0] group_sync_exclude;
        logic [1:0] align_pin_drive;
        logic       align_qualify;
        logic       align_pin_polarity;
        logic       crystal_osc_enable;
        logic [4:0] lock_pin_select;
        logic       dac_track;
        logic [1:0] holdover_cfg;
        logic [2:0] ref_input_select_mode;
        logic       status_pin_invert;
        logic       ref1_usable;
        logic       ref0_usable;
        logic [1:0] signal_loss_timeout;
        logic       signal_loss_detect_on;
        logic [2:0] status_pin1_io_type;
    } shcfg_ctrl_s;
endpackage

// ---- hw/shcfg_bank.sv ----
// Sync, holdover and reference input configuration bank.
// Assumes an AXI4-Lite master on clk; status pins are asynchronous.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "shcfg_defines.svh"

module shcfg_bank
(
    input  wire logic                   clk,            // 125 MHz clock
    input  wire logic                   rst_b,          // Async reset, active low
    input  wire logic [7:0]             s_axi_awaddr,   // Write address
    input  wire logic                   s_axi_awvalid,  // Write address valid
    output var  logic                   s_axi_awready,  // Write address ready
    input  wire logic [31:0]            s_axi_wdata,    // Write data
    input  wire logic [3:0]             s_axi_wstrb,    // Write strobes
    input  wire logic                   s_axi_wvalid,   // Write data valid
    output var  logic                   s_axi_wready,   // Write data ready
    output var  logic [1:0]             s_axi_bresp,    // Write response
    output var  logic                   s_axi_bvalid,   // Write response valid
    input  wire logic                   s_axi_bready,   // Write response ready
    input  wire logic [7:0]             s_axi_araddr,   // Read address
    input  wire logic                   s_axi_arvalid,  // Read address valid
    output var  logic                   s_axi_arready,  // Read address ready
    output var  logic [31:0]            s_axi_rdata,    // Read data
    output var  logic [1:0]             s_axi_rresp,    // Read response
    output var  logic                   s_axi_rvalid,   // Read data valid
    input  wire logic                   s_axi_rready,   // Read data ready
    input  wire logic                   align_pin_in,   // Sync pin level
    input  wire logic                   loop1_lock,     // Loop one lock detect
    input  wire logic                   loop2_lock,     // Loop two lock detect
    input  wire logic                   ref0_active,    // Reference 0 activity
    input  wire logic                   ref1_active,    // Reference 1 activity
    input  wire logic                   status_pin0_in, // Select pin 0
    input  wire logic                   status_pin1_in, // Select pin 1
    output var  shcfg_pkg::shcfg_ctrl_s ctrl,           // Decoded configuration
    output var  logic                   align_request,  // Alignment event pulse
    output var  logic                   align_hold,     // Alignment held active
    output var  logic                   holdover_enter, // Holdover entry pulse
    output var  logic [1:0]             pin_ref_select, // Polarity-fixed select pins
    output var  logic                   ref0_lost,      // Loss of signal, ref 0
    output var  logic                   ref1_lost       // Loss of signal, ref 1
);
    import shcfg_pkg::*;

    logic [31:0] out_path_reg, mode_sync_reg, lock_hold_reg, hold_pin_reg, sig_loss_reg;
    logic        soft_rst_reg;
    logic        aw_held_reg, w_held_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        wr_go;
    logic [7:0]  wr_idx, rd_idx;
    logic        wr_hit;
    logic [31:0] rd_word;
    logic        rd_hit;

    // Three-stage synchronisers for the async inputs
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, clean_reg;
    assign raw_in = {status_pin1_in, status_pin0_in, ref1_active, ref0_active,
                     loop2_lock, loop1_lock, align_pin_in};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            // A change counts only once stages two and three agree
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    s1_reg[gi]    <= 1'b0;
                    s2_reg[gi]    <= 1'b0;
                    s3_reg[gi]    <= 1'b0;
                    clean_reg[gi] <= 1'b0;
                end else begin
                    s1_reg[gi] <= raw_in[gi];
                    s2_reg[gi] <= s1_reg[gi];
                    s3_reg[gi] <= s2_reg[gi];
                    if (s2_reg[gi] == s3_reg[gi]) begin
                        clean_reg[gi] <= s3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    // Write capture: address and data in either order
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Ready drops while a word is held or a response is pending
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid
                             && !wr_go;
            s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid
                             && !wr_go;
        end
    end

    assign wr_go  = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_idx = {2'h0, aw_addr_reg[7:2]};
    // Whole-word writes only, so fields never tear
    assign wr_hit = (w_strb_reg == 4'hf) && (aw_addr_reg[1:0] == 2'h0) &&
                    (wr_idx == `SHCFG_IDX_OUT_PATH || wr_idx == `SHCFG_IDX_MODE_SYNC ||
                     wr_idx == `SHCFG_IDX_LOCK_HOLD || wr_idx == `SHCFG_IDX_HOLD_PIN ||
                     wr_idx == `SHCFG_IDX_SIG_LOSS || wr_idx == `SHCFG_IDX_DEV_RESET);

    // Write response
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= SHCFG_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? SHCFG_RESP_OKAY : SHCFG_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Soft reset pulse; acts one cycle after the write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= wr_go && wr_hit && wr_idx == `SHCFG_IDX_DEV_RESET
                            && w_data_reg[`SHCFG_B_DEV_RESET];
        end
    end

    // Configuration words; both resets load defaults
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_path_reg  <= `SHCFG_RST_OUT_PATH;
            mode_sync_reg <= `SHCFG_RST_MODE_SYNC;
            lock_hold_reg <= `SHCFG_RST_LOCK_HOLD;
            hold_pin_reg  <= `SHCFG_RST_HOLD_PIN;
            sig_loss_reg  <= `SHCFG_RST_SIG_LOSS;
        end else if (soft_rst_reg) begin
            out_path_reg  <= `SHCFG_RST_OUT_PATH;
            mode_sync_reg <= `SHCFG_RST_MODE_SYNC;
            lock_hold_reg <= `SHCFG_RST_LOCK_HOLD;
            hold_pin_reg  <= `SHCFG_RST_HOLD_PIN;
            sig_loss_reg  <= `SHCFG_RST_SIG_LOSS;
        end else if (wr_go && wr_hit) begin
            // Whole register replaced at once
            case (wr_idx)
                `SHCFG_IDX_OUT_PATH:  out_path_reg  <= w_data_reg;
                `SHCFG_IDX_MODE_SYNC: mode_sync_reg <= w_data_reg;
                `SHCFG_IDX_LOCK_HOLD: lock_hold_reg <= w_data_reg;
                `SHCFG_IDX_HOLD_PIN:  hold_pin_reg  <= w_data_reg;
                `SHCFG_IDX_SIG_LOSS:  sig_loss_reg  <= w_data_reg;
                default: ;
            endcase
        end
    end

    // Decoded fields, registered so outputs come from flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= '0;
        end else begin
            ctrl.osc_path_select       <= out_path_reg[`SHCFG_B_OSC_PATH];
            ctrl.feedback_mux_power    <= out_path_reg[`SHCFG_B_FB_MUX_EN];
            ctrl.feedback_select       <= out_path_reg[`SHCFG_B_FB_SEL_HI:`SHCFG_B_FB_SEL_LO];
            ctrl.group_sync_exclude    <= mode_sync_reg[`SHCFG_B_EXCL_HI:`SHCFG_B_EXCL_LO];
            ctrl.align_pin_drive       <= mode_sync_reg[`SHCFG_B_ALIGN_OUT_HI:`SHCFG_B_ALIGN_OUT_LO];
            ctrl.align_qualify         <= mode_sync_reg[`SHCFG_B_ALIGN_QUAL];
            ctrl.align_pin_polarity    <= mode_sync_reg[`SHCFG_B_ALIGN_POL];
            ctrl.crystal_osc_enable    <= mode_sync_reg[`SHCFG_B_XTAL_EN];
            ctrl.lock_pin_select       <= lock_hold_reg[`SHCFG_B_LOCK_SEL_HI:`SHCFG_B_LOCK_SEL_LO];
            ctrl.dac_track             <= lock_hold_reg[`SHCFG_B_TRACK];
            ctrl.holdover_cfg          <= lock_hold_reg[`SHCFG_B_HOLD_HI:`SHCFG_B_HOLD_LO];
            ctrl.ref_input_select_mode <= hold_pin_reg[`SHCFG_B_SEL_MODE_HI:`SHCFG_B_SEL_MODE_LO];
            ctrl.status_pin_invert     <= hold_pin_reg[`SHCFG_B_PIN_INV];
            ctrl.ref1_usable           <= hold_pin_reg[`SHCFG_B_REF1_OK];
            ctrl.ref0_usable           <= hold_pin_reg[`SHCFG_B_REF0_OK];
            ctrl.signal_loss_timeout   <= sig_loss_reg[`SHCFG_B_LOSS_TO_HI:`SHCFG_B_LOSS_TO_LO];
            ctrl.signal_loss_detect_on <= sig_loss_reg[`SHCFG_B_LOSS_ON];
            ctrl.status_pin1_io_type   <= sig_loss_reg[`SHCFG_B_ST1_TYPE_HI:`SHCFG_B_ST1_TYPE_LO];
        end
    end

    // Alignment events: pin edge, or a write to the reset command word when auto is set
    logic align_pin_prev_reg;
    logic pin_active, div_write;
    assign pin_active = clean_reg[0] ^ !mode_sync_reg[`SHCFG_B_ALIGN_POL];
    assign div_write  = wr_go && wr_hit && wr_idx <= 8'h05
                        && mode_sync_reg[`SHCFG_B_ALIGN_AUTO];
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            align_pin_prev_reg <= 1'b0;
            align_request      <= 1'b0;
        end else begin
            align_pin_prev_reg <= pin_active;
            align_request      <= (pin_active && !align_pin_prev_reg) || div_write;
        end
    end

    // Alignment held until selected loops lock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            align_hold <= 1'b0;
        end else begin
            align_hold <= (lock_hold_reg[`SHCFG_B_ALIGN_L2] && !clean_reg[2]) ||
                          (lock_hold_reg[`SHCFG_B_ALIGN_L1] && !clean_reg[1]);
        end
    end

    // Holdover entry on loop one lock loss, unless disabled
    logic loop1_prev_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            loop1_prev_reg <= 1'b0;
            holdover_enter <= 1'b0;
        end else begin
            loop1_prev_reg <= clean_reg[1];
            holdover_enter <= loop1_prev_reg && !clean_reg[1]
                              && !hold_pin_reg[`SHCFG_B_L1_TRIG_OFF]
                              && lock_hold_reg[`SHCFG_B_HOLD_HI:`SHCFG_B_HOLD_LO]
                                 == `SHCFG_HOLD_AUTO;
        end
    end

    // Select pins inverted only in pin-select mode
    logic pin_inv;
    assign pin_inv = hold_pin_reg[`SHCFG_B_PIN_INV] &&
                     hold_pin_reg[`SHCFG_B_SEL_MODE_HI:`SHCFG_B_SEL_MODE_LO]
                     == `SHCFG_SEL_MODE_PIN;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_ref_select <= 2'h0;
        end else begin
            pin_ref_select <= clean_reg[6:5] ^ {2{pin_inv}};
        end
    end

    // Loss-of-signal timers; only code 0 has a known length, others scale it
    localparam int LOSS_W = 12;
    logic [LOSS_W-1:0] loss_limit;
    logic [LOSS_W-1:0] loss_cnt_reg [2];
    logic [1:0]        act_prev_reg;
    logic [1:0]        lost_next;
    assign loss_limit = LOSS_W'(`SHCFG_LOSS_TO0_CYC) <<
                        sig_loss_reg[`SHCFG_B_LOSS_TO_HI:`SHCFG_B_LOSS_TO_LO];
    generate
        for (gi = 0; gi < 2; gi++) begin : g_loss
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    loss_cnt_reg[gi] <= '0;
                    act_prev_reg[gi] <= 1'b0;
                end else begin
                    act_prev_reg[gi] <= clean_reg[3+gi];
                    if (!sig_loss_reg[`SHCFG_B_LOSS_ON] ||
                        clean_reg[3+gi] != act_prev_reg[gi]) begin
                        loss_cnt_reg[gi] <= '0;
                    end else if (loss_cnt_reg[gi] < loss_limit) begin
                        loss_cnt_reg[gi] <= loss_cnt_reg[gi] + 1'b1;
                    end
                end
            end
            assign lost_next[gi] = sig_loss_reg[`SHCFG_B_LOSS_ON] &&
                                   loss_cnt_reg[gi] >= loss_limit;
        end
    endgenerate
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ref0_lost <= 1'b0;
            ref1_lost <= 1'b0;
        end else begin
            ref0_lost <= lost_next[0];
            ref1_lost <= lost_next[1];
        end
    end

    // Read decode; status word shows live block state
    assign rd_idx = {2'h0, s_axi_araddr[7:2]};
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h00000000;
        case (rd_idx)
            `SHCFG_IDX_OUT_PATH:   rd_word = out_path_reg;
            `SHCFG_IDX_MODE_SYNC:  rd_word = mode_sync_reg;
            `SHCFG_IDX_LOCK_HOLD:  rd_word = lock_hold_reg;
            `SHCFG_IDX_HOLD_PIN:   rd_word = hold_pin_reg;
            `SHCFG_IDX_SIG_LOSS:   rd_word = sig_loss_reg;
            `SHCFG_IDX_DEV_RESET:  rd_word = 32'h00000000;
            `SHCFG_IDX_STATUS:     rd_word = {26'h0, ref1_lost, ref0_lost, align_hold,
                                              pin_ref_select, clean_reg[1]};
            default:               rd_hit  = 1'b0;
        endcase
        if (s_axi_araddr[1:0] != 2'h0) begin
            rd_hit = 1'b0;
        end
    end

    // Read channel: one read at a time, answered next cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= SHCFG_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_hit ? rd_word : 32'h00000000;
                s_axi_rresp  <= rd_hit ? SHCFG_RESP_OKAY : SHCFG_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ---- verif/shcfg_bank_props.sv ----
// Port checker for the configuration bank.
// Assumes the bank's clk and rst_b; bound below.
`timescale 1ns/1ps
`default_nettype none
module shcfg_bank_props
(
    input wire logic                   clk,            // Clock
    input wire logic                   rst_b,          // Reset
    input wire logic                   s_axi_awvalid,  // Aw valid
    input wire logic                   s_axi_awready,  // Aw ready
    input wire logic                   s_axi_wvalid,   // W valid
    input wire logic                   s_axi_wready,   // W ready
    input wire logic [3:0]             s_axi_wstrb,    // Strobes
    input wire logic [1:0]             s_axi_bresp,    // B code
    input wire logic                   s_axi_bvalid,   // B valid
    input wire logic                   s_axi_arvalid,  // Ar valid
    input wire logic                   s_axi_arready,  // Ar ready
    input wire logic                   s_axi_rvalid,   // R valid
    input wire shcfg_pkg::shcfg_ctrl_s ctrl,           // Fields
    input wire logic                   align_request,  // Align pulse
    input wire logic                   holdover_enter  // Holdover pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Both write halves taken together
    logic wtake;
    assign wtake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    property p_dflt;
        $rose(rst_b) |-> ##1 (ctrl.lock_pin_select == 5'h03 && ctrl.holdover_cfg == 2'h2
            && ctrl.group_sync_exclude == 6'h18 && ctrl.align_pin_polarity && ctrl.dac_track
            && ctrl.ref_input_select_mode == 3'h3 && !ctrl.feedback_mux_power);
    endproperty
    a_dflt: assert property (p_dflt) else $error("defaults missing");
    property p_bans;
        wtake |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_bans: assert property (p_bans) else $error("no write answer");
    property p_berr;
        wtake && s_axi_wstrb != 4'hf |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == 2'h2);
    endproperty
    a_berr: assert property (p_berr) else $error("partial write accepted");
    property p_rans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rans: assert property (p_rans) else $error("no read answer");
    property p_arblk;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_arblk: assert property (p_arblk) else $error("read taken while busy");
    property p_wblk;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wblk: assert property (p_wblk) else $error("write taken while busy");
    property p_pulse;
        align_request |=> !align_request;
    endproperty
    a_pulse: assert property (p_pulse) else $error("align pulse too long");
    property p_hoen;
        holdover_enter |-> ctrl.holdover_cfg == 2'h2 && !$past(holdover_enter);
    endproperty
    a_hoen: assert property (p_hoen) else $error("bad holdover entry");
    c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    c_ho: cover property (holdover_enter);
    c_al: cover property (align_request);
endmodule
bind shcfg_bank shcfg_bank_props i_props (.*);
`default_nettype wire

// ---- verif/shcfg_host.sv ----
// Host model: AXI4-Lite master with one write and one read task.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
`default_nettype none
module shcfg_host (
    input  wire logic        clk,           // Clock
    output logic [7:0]       s_axi_awaddr,  // Aw address
    output logic             s_axi_awvalid, // Aw valid
    input  wire logic        s_axi_awready, // Aw ready
    output logic [31:0]      s_axi_wdata,   // W data
    output logic [3:0]       s_axi_wstrb,   // W strobes
    output logic             s_axi_wvalid,  // W valid
    input  wire logic        s_axi_wready,  // W ready
    input  wire logic [1:0]  s_axi_bresp,   // B code
    input  wire logic        s_axi_bvalid,  // B valid
    output logic             s_axi_bready,  // B ready
    output logic [7:0]       s_axi_araddr,  // Ar address
    output logic             s_axi_arvalid, // Ar valid
    input  wire logic        s_axi_arready, // Ar ready
    input  wire logic [31:0] s_axi_rdata,   // R data
    input  wire logic [1:0]  s_axi_rresp,   // R code
    input  wire logic        s_axi_rvalid,  // R valid
    output logic             s_axi_rready   // R ready
);
    // Idle bus until the first task
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    end
    // Whole word offered with address; each half dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            output logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (1) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // Read holds rready high until answered
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        while (1) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- verif/tb_sync_holdover_input_config_bank.sv ----
// Bench for the configuration bank.
// Assumes shcfg_host as master and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "shcfg_defines.svh"
module tb_sync_holdover_input_config_bank;
    import shcfg_pkg::*;
    logic clk, rst_b, align_pin_in, loop1_lock, loop2_lock, ref0_active, ref1_active;
    logic status_pin0_in, status_pin1_in, act, align_request, align_hold, holdover_enter;
    logic ref0_lost, ref1_lost, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, pin_ref_select, r;
    shcfg_ctrl_s ctrl;
    int miscompares, checks_done, cyc, n_al, n_ho, n;
    shcfg_bank i_dut (.*);
    shcfg_host i_host (.*);
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    // Pulse counters, activity toggles and the hang limit
    always @(posedge clk) begin
        n_al <= n_al + align_request;
        n_ho <= n_ho + holdover_enter;
        {ref0_active, ref1_active} <= act ? {2{cyc[2]}} : 2'h0;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            results();
        end
    end
    task w(input int c);
        repeat (c) @(posedge clk);
    endtask
    task chk(input logic [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task t_regs();
        logic [31:0] e [5] = '{`SHCFG_RST_OUT_PATH, `SHCFG_RST_MODE_SYNC,
            `SHCFG_RST_LOCK_HOLD, `SHCFG_RST_HOLD_PIN, `SHCFG_RST_SIG_LOSS};
        for (int i = 0; i < 5; i++) begin
            i_host.rd(8'(40 + 4 * i), d, r);
            chk(d, e[i]);
        end
        i_host.wr(8'h28, 32'h000010e0, 4'hf, r);
        w(2);
        chk({ctrl.osc_path_select, ctrl.feedback_select}, 4'hf);
        i_host.wr(8'h28, 32'h0, 4'h3, r);
        chk(r, 2'h2);
        i_host.rd(8'h28, d, r);
        chk(d, 32'h000010e0);
        i_host.rd(8'h44, d, r);
        chk(r, 2'h2);
        $display("registers done");
    endtask
    task t_pins();
        {status_pin1_in, status_pin0_in} <= 2'h1;
        i_host.wr(8'h34, 32'h3b020d60, 4'hf, r);
        w(8);
        chk(pin_ref_select, 2'h2);
        i_host.wr(8'h34, 32'h3b020760, 4'hf, r);
        w(8);
        chk(pin_ref_select, 2'h1);
        n = n_al;
        i_host.wr(8'h00, 32'h0, 4'hf, r);
        w(6);
        chk(n_al - n, 0);
        align_pin_in <= 1'b1;
        w(8);
        chk(n_al - n, 1);
        $display("pins done");
    endtask
    task t_lock();
        loop1_lock <= 1'b1;
        w(10);
        n = n_ho;
        loop1_lock <= 1'b0;
        w(10);
        chk(n_ho - n, 1);
        i_host.wr(8'h30, 32'h1b400180, 4'hf, r);
        w(8);
        chk(align_hold, 1'b1);
        i_host.wr(8'h34, 32'h3b028660, 4'hf, r);
        loop1_lock <= 1'b1;
        w(10);
        chk(align_hold, 1'b0);
        n = n_ho;
        loop1_lock <= 1'b0;
        w(10);
        chk(n_ho - n, 0);
        $display("lock done");
    endtask
    task t_loss();
        act <= 1'b1;
        w(20);
        act <= 1'b0;
        w(140);
        chk(ref0_lost, 1'b0);
        w(20);
        chk({ref1_lost, ref0_lost}, 2'h3);
        i_host.wr(8'h38, 32'h02000000, 4'hf, r);
        w(4);
        chk(ref0_lost, 1'b0);
        i_host.wr(8'h00, 32'h00020000, 4'hf, r);
        w(3);
        i_host.rd(8'h38, d, r);
        chk(d, `SHCFG_RST_SIG_LOSS);
        $display("loss done");
    endtask
    task results();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        {rst_b, align_pin_in, loop1_lock, loop2_lock, act, status_pin0_in, status_pin1_in} = 0;
        {miscompares, checks_done, cyc, n_al, n_ho} = 0;
        loop2_lock = 1'b1;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        w(2);
        t_regs();
        t_pins();
        t_lock();
        t_loss();
        results();
    end
endmodule
`default_nettype wire
